// File: hw/tuner_readback_regs.svh
// Offsets, field positions and reset values of the tuner readback group.
// Included by the capture and register modules, not by the package; definitions only.
`ifndef TUNER_READBACK_REGS_SVH
`define TUNER_READBACK_REGS_SVH

// Register indices; byte address is four times the index
`define IDX_TUNED_CHANNEL 8'h0B
`define IDX_BLOCK_FIRST 8'h0C
`define IDX_BLOCK_SECOND 8'h0D
`define IDX_BLOCK_THIRD 8'h0E
`define IDX_BLOCK_FOURTH 8'h0F
// Own control and status words
`define IDX_CONTROL 8'h02
`define IDX_STATUS 8'h0A

// Field positions in the channel readback word
`define POS_SECOND_ERR 14
`define POS_THIRD_ERR 12
`define POS_FOURTH_ERR 10
`define POS_CHANNEL 0
// Field positions in control and status words
`define POS_VERBOSE_SELECT 11
`define POS_BAND_LO 6
`define POS_SPACE_LO 4
`define POS_GROUP_READY 15

`define RESET_WORD 16'h0000
`define ERR_NONE 2'h0
`define ERR_FEW 2'h1
`define ERR_SOME 2'h2
`define ERR_FATAL 2'h3
`define BAND_EUROPE 2'h0
`define BAND_JAPAN_WIDE 2'h1
`define BAND_JAPAN 2'h2
// Band base frequencies in 10 kHz units
`define BASE_LOW_10K 16'h1DB0
`define BASE_HIGH_10K 16'h222E

`endif

// File: hw/tuner_readback_pkg.sv
// Types shared by the readback register group.
// Constants live in tuner_readback_regs.svh.
package tuner_readback_pkg;
  typedef logic [15:0] word_t;
  typedef logic [1:0] err_t;
  typedef logic [9:0] tune_channel_field_t;
  typedef enum logic [1:0] {
    ACC_IDLE,
    ACC_SETUP,
    ACC_DONE
  } apb_phase_e;
endpackage

// File: hw/block_capture.sv
// Group capture of the four data words and their error levels.
// Assumes the decoder presents a whole group with a one-cycle strobe.
`timescale 1ns/1ps
`include "tuner_readback_regs.svh"

module block_capture
  import tuner_readback_pkg::*;
#(
  parameter int NBLK = 4
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic group_strobe,
  input wire logic [16*NBLK-1:0] group_words,
  input wire logic [2*NBLK-1:0] group_errs,
  input wire logic ready_clear,
  output logic [16*NBLK-1:0] words_ff,
  output logic [2*NBLK-1:0] errs_ff,
  output logic group_ready_flag
);
  logic [16*NBLK-1:0] nxt_words;
  logic [2*NBLK-1:0] nxt_errs;
  logic ready_ff;
  logic nxt_ready;

  assign group_ready_flag = ready_ff;

  always_comb begin
    nxt_words = words_ff;
    nxt_errs = errs_ff;
    nxt_ready = ready_ff;
    if (ready_clear) begin
      nxt_ready = 1'b0;
    end
    if (group_strobe) begin
      // All words and levels load together
      nxt_words = group_words;
      nxt_errs = group_errs;
      // Set wins over a clear in the same cycle
      nxt_ready = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      words_ff <= '0;
      errs_ff <= '0;
      ready_ff <= 1'b0;
    end else begin
      words_ff <= nxt_words;
      errs_ff <= nxt_errs;
      ready_ff <= nxt_ready;
    end
  end
endmodule

// File: hw/tuner_readback_registers.sv
// Readback register group of an FM tuner behind an APB slave.
// Assumes a tuning core and a data decoder drive the status inputs.
`timescale 1ns/1ps
`include "tuner_readback_regs.svh"

module tuner_readback_registers
  import tuner_readback_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic rst_n_pin,
  input wire logic serial_select_n_pin,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic tune_channel_field_update,
  input wire logic [9:0] tune_channel_field_value,
  input wire logic group_strobe,
  input wire logic [63:0] group_words,
  input wire logic [7:0] group_errs,
  output logic verbose_report_select,
  output logic [1:0] band_select,
  output logic [1:0] space_select,
  output logic [15:0] tuned_freq_khz,
  output logic device_active
);
  function automatic logic [7:0] word_index(input logic [11:0] a);
    word_index = a[9:2];
  endfunction

  function automatic logic hit(input logic [11:0] a, input logic [7:0] idx);
    hit = (a[1:0] == 2'b00) && (a[11:10] == 2'b00) && (word_index(a) == idx);
  endfunction

  function automatic logic [15:0] scaled_tune_channel_field(input logic [9:0] ch,
    input int sh);
    scaled_tune_channel_field = 16'({6'h00, ch} << sh);
  endfunction

  // Byte-lane merge; only the low two lanes hold register bits
  function automatic logic [15:0] lane_merge(input logic [15:0] old,
    input logic [15:0] data, input logic [1:0] strb);
    lane_merge = old;
    if (strb[0]) begin
      lane_merge[7:0] = data[7:0];
    end
    if (strb[1]) begin
      lane_merge[15:8] = data[15:8];
    end
  endfunction

  // Internal reset joins bus reset and the active-low pin
  logic dev_rst;
  assign dev_rst = rst | ~rst_n_pin;

  logic [9:0] tune_channel_field_ff;
  logic [9:0] nxt_tune_channel_field;
  logic [15:0] ctrl_ff;
  logic [15:0] nxt_ctrl;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  apb_phase_e phase_ff;
  apb_phase_e nxt_phase;
  logic [63:0] words;
  logic [7:0] errs;
  logic ready_flag;
  logic ready_clear;
  logic setup_seen;
  logic access;
  logic wr_ok;
  logic rd_setup;
  logic [6:0] reg_sel;
  logic [15:0] rd_word;
  logic [15:0] status_word;
  logic [15:0] readback_word;
  logic [5:0] err_field;
  logic [15:0] prod_ff;
  logic [15:0] nxt_prod;
  logic [15:0] base_ff;
  logic [15:0] nxt_base;
  logic [15:0] nxt_freq;

  block_capture #(
    .NBLK(4)
  ) u_capture (
    .clk_sys(clk_sys),
    .rst(dev_rst),
    .group_strobe(group_strobe),
    .group_words(group_words),
    .group_errs(group_errs),
    .ready_clear(ready_clear),
    .words_ff(words),
    .errs_ff(errs),
    .group_ready_flag(ready_flag)
  );

  assign verbose_report_select = ctrl_ff[`POS_VERBOSE_SELECT];
  assign band_select = ctrl_ff[`POS_BAND_LO +: 2];
  assign space_select = ctrl_ff[`POS_SPACE_LO +: 2];
  // Bus access blocked while the serial select is inactive
  assign device_active = ~serial_select_n_pin;

  // Error levels masked outside verbose mode; host must not rely on them
  always_comb begin
    err_field = 6'h00;
    if (verbose_report_select) begin
      err_field[5:4] = errs[3:2];
      err_field[3:2] = errs[5:4];
      err_field[1:0] = errs[7:6];
    end
  end
  assign readback_word = {err_field, tune_channel_field_ff};

  // Frequency in 10 kHz units: every base and step is a whole multiple,
  // so shifts and adds stand in for a multiplier and a divider
  always_comb begin
    case (space_select)
      2'h0: begin
        // 200 kHz steps
        nxt_prod = scaled_tune_channel_field(tune_channel_field_ff, 4) + scaled_tune_channel_field(tune_channel_field_ff, 2);
      end
      2'h1: begin
        // 100 kHz steps
        nxt_prod = scaled_tune_channel_field(tune_channel_field_ff, 3) + scaled_tune_channel_field(tune_channel_field_ff, 1);
      end
      default: begin
        // 50 kHz steps
        nxt_prod = scaled_tune_channel_field(tune_channel_field_ff, 2) + scaled_tune_channel_field(tune_channel_field_ff, 0);
      end
    endcase
    if (band_select == `BAND_EUROPE) begin
      nxt_base = `BASE_HIGH_10K;
    end else begin
      nxt_base = `BASE_LOW_10K;
    end
    nxt_freq = 16'(base_ff + prod_ff);
  end

  // Extra stage keeps the adder off the shift path; costs one cycle
  always_ff @(posedge clk_sys) begin
    if (dev_rst) begin
      prod_ff <= 16'h0000;
      base_ff <= 16'h0000;
      tuned_freq_khz <= 16'h0000;
    end else begin
      prod_ff <= nxt_prod;
      base_ff <= nxt_base;
      tuned_freq_khz <= nxt_freq;
    end
  end

  // Channel tracks tuning core during seek and at completion
  always_comb begin
    nxt_tune_channel_field = tune_channel_field_ff;
    if (tune_channel_field_update) begin
      nxt_tune_channel_field = tune_channel_field_value;
    end
  end

  // APB slave: answers in the first access cycle
  always_comb begin
    setup_seen = psel & ~penable;
    access = psel & penable & (phase_ff == ACC_SETUP);
    wr_ok = access & pwrite & device_active;
    rd_setup = setup_seen & ~pwrite & device_active;
    ready_clear = access & ~pwrite & device_active & reg_sel[6];
  end
  assign pready = access;
  assign pslverr = 1'b0;

  always_comb begin
    nxt_phase = phase_ff;
    case (phase_ff)
      ACC_IDLE: begin
        if (psel & ~penable) begin
          nxt_phase = ACC_SETUP;
        end
      end
      ACC_SETUP: begin
        if (psel & penable) begin
          nxt_phase = ACC_DONE;
        end
      end
      ACC_DONE: begin
        if (psel & ~penable) begin
          nxt_phase = ACC_SETUP;
        end else begin
          nxt_phase = ACC_IDLE;
        end
      end
      default: nxt_phase = ACC_IDLE;
    endcase
  end

  always_comb begin
    nxt_ctrl = ctrl_ff;
    // Only the control word has a write path
    if (wr_ok && reg_sel[0]) begin
      nxt_ctrl = lane_merge(ctrl_ff, pwdata[15:0], pstrb[1:0]);
    end
  end

  // One-hot word decode shared by the read mux and the flag clear
  always_comb begin
    reg_sel = 7'h00;
    if (hit(paddr, `IDX_CONTROL)) begin
      reg_sel[0] = 1'b1;
    end
    if (hit(paddr, `IDX_STATUS)) begin
      reg_sel[1] = 1'b1;
    end
    if (hit(paddr, `IDX_TUNED_CHANNEL)) begin
      reg_sel[2] = 1'b1;
    end
    if (hit(paddr, `IDX_BLOCK_FIRST)) begin
      reg_sel[3] = 1'b1;
    end
    if (hit(paddr, `IDX_BLOCK_SECOND)) begin
      reg_sel[4] = 1'b1;
    end
    if (hit(paddr, `IDX_BLOCK_THIRD)) begin
      reg_sel[5] = 1'b1;
    end
    if (hit(paddr, `IDX_BLOCK_FOURTH)) begin
      reg_sel[6] = 1'b1;
    end
  end

  assign status_word = {ready_flag, 15'h0000};

  // Unmapped words read as zero rather than raising an error
  always_comb begin
    case (reg_sel)
      7'h01: rd_word = ctrl_ff;
      7'h02: rd_word = status_word;
      7'h04: rd_word = readback_word;
      7'h08: rd_word = words[15:0];
      7'h10: rd_word = words[31:16];
      7'h20: rd_word = words[47:32];
      7'h40: rd_word = words[63:48];
      default: rd_word = `RESET_WORD;
    endcase
  end

  // Read data latched at setup so it stands through the access cycle
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (rd_setup) begin
      nxt_rdata = {16'h0000, rd_word};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (dev_rst) begin
      rdata_ff <= 32'h0000_0000;
      phase_ff <= ACC_IDLE;
    end else begin
      rdata_ff <= nxt_rdata;
      phase_ff <= nxt_phase;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (dev_rst) begin
      tune_channel_field_ff <= 10'h000;
    end else begin
      tune_channel_field_ff <= nxt_tune_channel_field;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (dev_rst) begin
      ctrl_ff <= `RESET_WORD;
    end else begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  assign prdata = rdata_ff;
endmodule

// File: tb/tuner_readback_chk.sv
// Assertions on the readback group's bus and control ports.
// Bound to the top module from the bench; sees its ports only.
`timescale 1ns/1ps
module tuner_readback_chk (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic rst_n_pin,
  input wire logic serial_select_n_pin,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic verbose_report_select,
  input wire logic [1:0] band_select,
  input wire logic device_active
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst || !rst_n_pin);
  wire logic ctl_wr;
  assign ctl_wr = psel && penable && pwrite && paddr == 12'h008
    && !serial_select_n_pin;
  sequence access;
    psel && penable;
  endsequence
  sequence tune_channel_field_setup;
    psel && !penable && !pwrite && paddr == 12'h02C;
  endsequence
  ready_in_access_a:
    assert property (access |-> pready) else $error("ready missing");
  upper_half_zero_a:
    assert property ((access and !pwrite) |-> prdata[31:16] == 16'h0000)
    else $error("upper read bits set");
  reset_clears_a:
    assert property (disable iff (1'h0) (rst || !rst_n_pin) |=>
      prdata == 32'h0000_0000) else $error("read data not cleared");
  deselect_read_a:
    assert property (psel && !penable && !pwrite && serial_select_n_pin
      |=> prdata == 32'h0000_0000) else $error("deselected read not 0");
  err_hidden_a:
    assert property (tune_channel_field_setup ##0 !verbose_report_select
      && !serial_select_n_pin |=> prdata[15:10] == 6'h00)
    else $error("error levels shown while not verbose");
  verbose_write_a:
    assert property (ctl_wr && pstrb[1] |=>
      verbose_report_select == $past(pwdata[11])) else $error("verbose");
  band_hold_a:
    assert property (!ctl_wr |=> $stable(band_select))
    else $error("band changed without write");
  active_pin_a:
    assert property (device_active == !serial_select_n_pin)
    else $error("active flag wrong");
  no_err_resp_a:
    assert property (!pslverr) else $error("error response");
endmodule

// File: tb/tuner_core_model.sv
// Tuning core and data decoder model feeding the readback group.
// Bench calls its tasks; outputs move just after a rising edge.
`timescale 1ns/1ps
module tuner_core_model (
  input wire logic clk_sys,
  output logic tune_channel_field_update = 1'h0,
  output logic [9:0] tune_channel_field_value = 10'h000,
  output logic group_strobe = 1'h0,
  output logic [63:0] group_words = 64'h0000_0000_0000_0000,
  output logic [7:0] group_errs = 8'h00
);
  task automatic tune(input logic [9:0] ch);
    @(posedge clk_sys);
    tune_channel_field_update <= 1'h1;
    tune_channel_field_value <= ch;
    @(posedge clk_sys);
    tune_channel_field_update <= 1'h0;
    tune_channel_field_value <= ~ch; // Not held past the pulse
  endtask
  task automatic send(input logic [63:0] w, input logic [7:0] e);
    @(posedge clk_sys);
    group_strobe <= 1'h1;
    group_words <= w;
    group_errs <= e;
    @(posedge clk_sys);
    group_strobe <= 1'h0;
    group_words <= ~w;
    group_errs <= ~e;
  endtask
endmodule

// File: tb/tuner_readback_registers_test.sv
// Self-checking bench of the tuner readback register group.
// Drives APB itself; the core model supplies channels and groups.
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin \
  error_cnt++; $display("[ERR] t=%0t got %h exp %h", $time, g, e); end end
module tuner_readback_registers_test
  import tuner_readback_pkg::*;
;
  logic clk_sys = 1'h0, rst = 1'h1, rst_n_pin = 1'h1;
  logic serial_select_n_pin = 1'h0, psel = 1'h0, penable = 1'h0;
  logic pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, q;
  logic [3:0] pstrb = 4'hF;
  wire logic [31:0] prdata;
  wire logic pready, pslverr, verbose_report_select, device_active;
  wire logic tune_channel_field_update, group_strobe;
  wire logic [1:0] band_select, space_select;
  wire word_t tuned_freq_khz;
  wire logic [9:0] tune_channel_field_value;
  wire logic [63:0] group_words;
  wire logic [7:0] group_errs;
  int error_cnt = 0, check_count = 0;
  tuner_readback_registers uut (.*);
  tuner_core_model core (.*);
  initial forever #20 clk_sys = ~clk_sys;
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'h1;
    @(posedge clk_sys);
    while (pready !== 1'h1) @(posedge clk_sys);
    q = prdata;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0000_0000);
    `CHK(q, e)
  endtask
  task automatic ctl(input logic v, input logic [1:0] b, s);
    apb(1'h1, 12'h008, {20'h0_0000, v, 3'h0, b, s, 4'h0});
  endtask
  task automatic fq(input logic [1:0] b, s, input word_t e);
    ctl(1'h0, b, s);
    repeat (2) @(posedge clk_sys);
    #1 `CHK(tuned_freq_khz, e)
    `CHK(band_select, b)
    `CHK(space_select, s)
  endtask
  task automatic t_reset;
    for (int a = 12'h02C; a <= 12'h03C; a += 4) rd(a[11:0], 32'h0);
    $display("reset values done");
  endtask
  task automatic t_tune_channel_field;
    core.tune(10'h3FF);
    rd(12'h02C, 32'h0000_03FF);
    core.tune(10'h005);
    fq(2'h0, 2'h0, 16'h2292);
    fq(2'h1, 2'h1, 16'h1DE2);
    fq(2'h2, 2'h2, 16'h1DC9);
    $display("channel done");
  endtask
  task automatic t_group;
    core.send(64'hD4D4_C3C3_B2B2_A1A1, 8'hE4);
    apb(1'h0, 12'h028, 32'h0);
    `CHK(q[15], 1'h1)
    rd(12'h02C, 32'h0000_0005);
    ctl(1'h1, 2'h0, 2'h0);
    rd(12'h02C, 32'h0000_6C05);
    `CHK(verbose_report_select, 1'h1)
    rd(12'h030, 32'h0000_A1A1);
    rd(12'h034, 32'h0000_B2B2);
    rd(12'h038, 32'h0000_C3C3);
    rd(12'h03C, 32'h0000_D4D4);
    apb(1'h0, 12'h028, 32'h0);
    `CHK(q[15], 1'h0)
    $display("group done");
  endtask
  task automatic t_ro;
    apb(1'h1, 12'h02C, 32'h0000_FFFF);
    apb(1'h1, 12'h034, 32'h0000_0000);
    rd(12'h02C, 32'h0000_6C05);
    rd(12'h034, 32'h0000_B2B2);
    $display("read only done");
  endtask
  task automatic t_pins;
    @(posedge clk_sys);
    serial_select_n_pin <= 1'h1;
    rd(12'h030, 32'h0);
    `CHK(device_active, 1'h0)
    serial_select_n_pin <= 1'h0;
    @(posedge clk_sys);
    rst_n_pin <= 1'h0;
    @(posedge clk_sys);
    rst_n_pin <= 1'h1;
    rd(12'h030, 32'h0);
    rd(12'h02C, 32'h0);
    rd(12'h028, 32'h0);
    $display("pins done");
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk_sys);
    rst <= 1'h0;
    t_reset;
    t_tune_channel_field;
    t_group;
    t_ro;
    t_pins;
    test_done;
  end
  initial begin
    repeat (3000) @(posedge clk_sys);
    error_cnt++;
    test_done;
  end
endmodule
bind tuner_readback_registers tuner_readback_chk chk (.*);
